// file: rtl/ofm_params.svh
// Purpose: constants for the overfrequency monitor element
// Assumes: 25 MHz clock, APB register map with word-aligned offsets
// Notes:   frequency in 0.01 Hz units, voltage in 0.1 % of nominal units
`ifndef OFM_PARAMS_SVH
`define OFM_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFM_ADDR_CTRL      12'h000
`define OFM_ADDR_PICKUP    12'h004
`define OFM_ADDR_DELAY     12'h008
`define OFM_ADDR_STATUS    12'h00C
`define OFM_ADDR_IRQ_STAT  12'h010
`define OFM_ADDR_IRQ_MASK  12'h014
`define OFM_ADDR_FREQ      12'h018
`define OFM_ADDR_CMD       12'h01C

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define OFM_CTRL_RST       7'h00
`define OFM_PICKUP_MIN     13'h07D0
`define OFM_PICKUP_MAX     13'h1964
`define OFM_PICKUP_RST     13'h17A2
`define OFM_DELAY_MAX      16'hEA60
`define OFM_DELAY_RST      16'h0032
`define OFM_VSUP_THRESH    10'h12C
`define OFM_MASK_RST       3'h0
`define OFM_CMD_RESET_BIT  0

// ------------------------------------------------------------
// timing: one delay step of 0.1 s
// ------------------------------------------------------------
`define OFM_CLK_HZ         25000000
`define OFM_STEP_MS        100
`define OFM_STEP_CYCLES    ((`OFM_CLK_HZ / 1000) * `OFM_STEP_MS)

`endif

// file: rtl/ofm_pkg.sv
// Purpose: types for the overfrequency monitor element
// Assumes: nothing
// Notes:   one-hot codes written out
package ofm_pkg;
    typedef enum logic [3:0] {
        OFM_FN_DISABLED = 4'h1,
        OFM_FN_ALARM    = 4'h2,
        OFM_FN_LATCHED  = 4'h4,
        OFM_FN_CONTROL  = 4'h8
    } ofm_func_t;

    typedef enum logic [3:0] {
        OFM_ST_IDLE    = 4'h1,
        OFM_ST_TIMING  = 4'h2,
        OFM_ST_OPERATE = 4'h4,
        OFM_ST_LATCHED = 4'h8
    } ofm_state_t;
endpackage : ofm_pkg

// file: rtl/ofm_tick.sv
// Purpose: 0.1 s tick generator for the delay timer
// Assumes: i_clear restarts the step so timing starts from a whole step
// Notes:   one-cycle pulse on o_tick
`timescale 1ns/100ps
`default_nettype none
`include "ofm_params.svh"

module ofm_tick (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_clear,
    output logic      o_tick
);
    parameter int unsigned STEP_CYCLES = `OFM_STEP_CYCLES;

    logic [23:0] cnt_ff;
    logic [23:0] nxt_cnt;
    logic        wrap;

    // counter wraps once per step
    assign wrap    = (cnt_ff == 24'(STEP_CYCLES - 1));
    assign nxt_cnt = (i_clear || wrap) ? 24'h000000 : cnt_ff + 24'h000001;

    // count and pulse
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_ff <= 24'h000000;
            o_tick <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            o_tick <= wrap && !i_clear;
        end
    end
endmodule // ofm_tick
`default_nettype wire

// file: rtl/ofm_monitor.sv
// Purpose: overfrequency monitor element with APB registers
// Assumes: i_freq in 0.01 Hz and i_volt_a in 0.1 % nominal, from async front end
// Notes:   inputs are synchronised before use; delay counted in 0.1 s steps
// Operation
// RULE1 - inhibit while phase A voltage at most 30%
// RULE2 - timer runs only above voltage and pickup
// RULE3 - voltage loss resets running timer silently
// RULE4 - function selects disabled alarm latched control
// RULE5 - frequency always measured and readable
// RULE6 - any combination of relays three to seven
// RULE7 - pickup 20.00 to 65.00 Hz, default 60.50
// RULE8 - condition beyond delay raises alarm, energises relays
// RULE9 - delay 0.0 to 6000.0 s, default 5.0
// RULE10 - latched alarm holds until reset command
// RULE11 - disabled never alarms nor energises relays
`timescale 1ns/100ps
`default_nettype none
`include "ofm_params.svh"

module ofm_monitor (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [12:0] i_freq,
    input  wire logic [9:0]  i_volt_a,
    output logic             o_alarm,
    output logic             o_control,
    output logic      [4:0]  o_relays,
    output logic             o_irq
);
    parameter int unsigned STEP_CYCLES = `OFM_STEP_CYCLES;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [12:0] freq_s1_ff;
    logic [12:0] freq_ff;
    logic [9:0]  volt_s1_ff;
    logic [9:0]  volt_ff;

    // multi-bit values from the front end assumed slow and stable between samples;
    // a word caught mid-change is off for one sample only, and the delay timer
    // (whole 0.1 s steps) swamps that, so no handshake is spent on it
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            freq_s1_ff <= 13'h0000;
            freq_ff    <= 13'h0000;
            volt_s1_ff <= 10'h000;
            volt_ff    <= 10'h000;
        end else begin
            freq_s1_ff <= i_freq;
            freq_ff    <= freq_s1_ff;
            volt_s1_ff <= i_volt_a;
            volt_ff    <= volt_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0]  func_ff;
    logic [4:0]  relay_sel_ff;
    logic [12:0] pickup_ff;
    logic [15:0] delay_ff;
    logic [2:0]  irq_stat_ff;
    logic [2:0]  irq_mask_ff;

    ofm_pkg::ofm_state_t state_ff;
    ofm_pkg::ofm_state_t nxt_state;
    logic [15:0] steps_ff;
    logic [15:0] nxt_steps;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    // apb decode
    wire setup_acc  = i_psel && !i_penable;
    wire wr_acc     = i_psel && i_penable && i_pwrite && o_pready;
    wire rd_acc     = i_psel && i_penable && !i_pwrite && o_pready;
    wire hit_ctrl   = (i_paddr == `OFM_ADDR_CTRL);
    wire hit_pickup = (i_paddr == `OFM_ADDR_PICKUP);
    wire hit_delay  = (i_paddr == `OFM_ADDR_DELAY);
    wire hit_status = (i_paddr == `OFM_ADDR_STATUS);
    wire hit_istat  = (i_paddr == `OFM_ADDR_IRQ_STAT);
    wire hit_imask  = (i_paddr == `OFM_ADDR_IRQ_MASK);
    wire hit_freq   = (i_paddr == `OFM_ADDR_FREQ);
    wire hit_cmd    = (i_paddr == `OFM_ADDR_CMD);
    wire hit_any    = hit_ctrl | hit_pickup | hit_delay | hit_status |
                      hit_istat | hit_imask | hit_freq | hit_cmd;

    // function code check: exactly one hot bit is legal
    function automatic logic ofm_func_ok(input logic [3:0] f);
        ofm_func_ok = (f == 4'h1) || (f == 4'h2) || (f == 4'h4) || (f == 4'h8);
    endfunction

    // out-of-range settings are refused, keeping the stored value
    wire        func_ok   = ofm_func_ok(i_pwdata[3:0]);
    wire [12:0] wr_pick   = i_pwdata[12:0];
    wire        pick_ok   = (i_pwdata[31:13] == 19'h00000) &&
                            (wr_pick >= `OFM_PICKUP_MIN) && (wr_pick <= `OFM_PICKUP_MAX);
    wire        delay_ok  = (i_pwdata[31:16] == 16'h0000) && (i_pwdata[15:0] <= `OFM_DELAY_MAX);
    wire        bad_value = (hit_ctrl && !func_ok) || (hit_pickup && !pick_ok) ||
                            (hit_delay && !delay_ok);
    wire        reset_cmd = wr_acc && hit_cmd && i_pwdata[`OFM_CMD_RESET_BIT];

    // pready comes one cycle after setup, so every access takes two cycles
    // a registered answer keeps the decode off the bus path without adding a wait state
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= setup_acc;
        end
    end

    // setting registers
    // a refused value leaves the old setting, so a bad write never half-applies
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            func_ff      <= ofm_pkg::OFM_FN_DISABLED;
            relay_sel_ff <= 5'h00;
            pickup_ff    <= `OFM_PICKUP_RST;                       // [RULE7]
            delay_ff     <= `OFM_DELAY_RST;                        // [RULE9]
            irq_mask_ff  <= `OFM_MASK_RST;
        end else if (wr_acc) begin
            if (hit_ctrl && func_ok) begin
                func_ff      <= i_pwdata[3:0];                     // [RULE4]
                relay_sel_ff <= i_pwdata[8:4];                     // [RULE6]
            end
            if (hit_pickup && pick_ok) pickup_ff <= wr_pick;       // [RULE7]
            if (hit_delay && delay_ok) delay_ff <= i_pwdata[15:0]; // [RULE9]
            if (hit_imask) irq_mask_ff <= i_pwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // detection and delay timer
    // ------------------------------------------------------------
    // strict compares: a reading equal to a threshold does not count
    wire volt_ok   = (volt_ff > `OFM_VSUP_THRESH);                 // [RULE1]
    wire over_freq = (freq_ff > pickup_ff);
    wire enabled   = (func_ff != ofm_pkg::OFM_FN_DISABLED);        // [RULE11]
    wire picked    = enabled && volt_ok && over_freq;              // [RULE2]
    wire tick;
    wire expired   = (steps_ff >= delay_ff);

    // the step counter restarts on every timing entry so the first step is whole
    ofm_tick #(.STEP_CYCLES(STEP_CYCLES)) u_tick (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_clear (state_ff != ofm_pkg::OFM_ST_TIMING),
        .o_tick  (tick)
    );

    // state machine: operate follows the condition, latched holds until a reset command or a disable
    // operate drops with the condition except in latched mode, which waits
    // a reset command is ignored in operate; in latched, with the condition back, it starts a fresh timing run
    always_comb begin
        nxt_state = state_ff;
        nxt_steps = steps_ff;
        unique case (state_ff)
            ofm_pkg::OFM_ST_IDLE: begin
                nxt_steps = 16'h0000;
                if (picked) nxt_state = ofm_pkg::OFM_ST_TIMING;    // [RULE2]
            end
            ofm_pkg::OFM_ST_TIMING: begin
                if (!picked) begin
                    nxt_state = ofm_pkg::OFM_ST_IDLE;              // [RULE3]
                    nxt_steps = 16'h0000;
                end else if (expired) begin
                    nxt_state = ofm_pkg::OFM_ST_OPERATE;           // [RULE8]
                end else if (tick) begin
                    nxt_steps = steps_ff + 16'h0001;
                end
            end
            ofm_pkg::OFM_ST_OPERATE: begin
                if (!enabled) begin
                    nxt_state = ofm_pkg::OFM_ST_IDLE;              // [RULE11]
                end else if (!picked) begin
                    nxt_state = (func_ff == ofm_pkg::OFM_FN_LATCHED) ?
                                ofm_pkg::OFM_ST_LATCHED : ofm_pkg::OFM_ST_IDLE; // [RULE10]
                end
            end
            ofm_pkg::OFM_ST_LATCHED: begin
                if (!enabled || reset_cmd) nxt_state = ofm_pkg::OFM_ST_IDLE; // [RULE10]
            end
            default: nxt_state = ofm_pkg::OFM_ST_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff <= ofm_pkg::OFM_ST_IDLE;
            steps_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            steps_ff <= nxt_steps;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire active   = enabled && ((state_ff == ofm_pkg::OFM_ST_OPERATE) ||
                                (state_ff == ofm_pkg::OFM_ST_LATCHED));
    wire is_ctrl  = (func_ff == ofm_pkg::OFM_FN_CONTROL);
    wire nxt_alm  = active && !is_ctrl;                            // [RULE4]
    wire nxt_ctl  = active && is_ctrl;                             // [RULE4]
    wire [4:0] nxt_rly = active ? relay_sel_ff : 5'h00;            // [RULE6]

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    // irq events: operate, pickup start, timer reset by any loss of pickup (voltage, frequency or disable)
    wire ev_oper  = (state_ff == ofm_pkg::OFM_ST_TIMING) && (nxt_state == ofm_pkg::OFM_ST_OPERATE);
    wire ev_pick  = (state_ff == ofm_pkg::OFM_ST_IDLE) && (nxt_state == ofm_pkg::OFM_ST_TIMING);
    wire ev_abort = (state_ff == ofm_pkg::OFM_ST_TIMING) && (nxt_state == ofm_pkg::OFM_ST_IDLE);
    wire [2:0] events  = {ev_abort, ev_pick, ev_oper};
    wire       istat_rd = rd_acc && hit_istat;
    // set wins over the read clear, so only an event raised in the read's setup cycle is lost
    wire [2:0] nxt_istat = (istat_rd ? 3'h0 : irq_stat_ff) | events;

    // output flops
    // every output leaves a flop so the pins never glitch on decode
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_alarm     <= 1'b0;
            o_control   <= 1'b0;
            o_relays    <= 5'h00;
            irq_stat_ff <= 3'h0;
            o_irq       <= 1'b0;
        end else begin
            o_alarm     <= nxt_alm;                                // [RULE8]
            o_control   <= nxt_ctl;
            o_relays    <= nxt_rly;                                // [RULE8]
            irq_stat_ff <= nxt_istat;
            o_irq       <= |(nxt_istat & irq_mask_ff);
        end
    end

    // read mux; frequency stays readable whatever the function setting
    // unmapped offsets read as zero and answer with pslverr
    wire [31:0] rd_mux =
        hit_ctrl   ? {23'h000000, relay_sel_ff, func_ff} :
        hit_pickup ? {19'h00000, pickup_ff} :
        hit_delay  ? {16'h0000, delay_ff} :
        hit_status ? {12'h000, steps_ff, state_ff} :
        hit_istat  ? {29'h00000000, irq_stat_ff} :
        hit_imask  ? {29'h00000000, irq_mask_ff} :
        hit_freq   ? {19'h00000, freq_ff} :                        // [RULE5]
        32'h00000000;

    // read data and error captured in setup so they are valid with pready
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_prdata  <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (setup_acc) begin
            o_prdata  <= i_pwrite ? 32'h00000000 : rd_mux;
            o_pslverr <= !hit_any || (i_pwrite && bad_value);
        end else begin
            o_pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks: element
    // ------------------------------------------------------------
    // outputs lag the state by one edge, so output checks look one cycle on
    chk_low_volt_inhibit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE1]
        (state_ff == ofm_pkg::OFM_ST_IDLE && !volt_ok) |=> (state_ff == ofm_pkg::OFM_ST_IDLE))
        else $error("timer started at low voltage");
    chk_timer_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE2]
        (steps_ff != $past(steps_ff) && steps_ff != 16'h0000) |-> $past(picked))
        else $error("timer advanced without pickup");
    chk_abort_silent: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE3]
        (state_ff == ofm_pkg::OFM_ST_TIMING && !volt_ok) |=>
        (state_ff == ofm_pkg::OFM_ST_IDLE) ##1 (!o_alarm && !o_control && o_relays == 5'h00))
        else $error("voltage loss did not reset silently");
    chk_control_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE4]
        o_control |-> !o_alarm)
        else $error("control and alarm both high");
    chk_alarm_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE4]
        o_alarm |-> ($past(func_ff) != ofm_pkg::OFM_FN_CONTROL))
        else $error("alarm raised in control mode");
    chk_freq_readable: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE5]
        (rd_acc && hit_freq) |-> (o_prdata == {19'h00000, $past(freq_ff)}))
        else $error("frequency read mismatch");
    chk_relay_select: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE6]
        (o_relays & ~$past(relay_sel_ff)) == 5'h00)
        else $error("unselected relay energised");
    chk_pickup_range: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE7]
        pickup_ff >= `OFM_PICKUP_MIN && pickup_ff <= `OFM_PICKUP_MAX)
        else $error("pickup out of range");
    chk_operate_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE8]
        (state_ff == ofm_pkg::OFM_ST_OPERATE && enabled) |=> (o_alarm || o_control))
        else $error("operate without output");
    chk_delay_range: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE9]
        delay_ff <= `OFM_DELAY_MAX)
        else $error("delay out of range");
    chk_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE10]
        (state_ff == ofm_pkg::OFM_ST_LATCHED && func_ff == ofm_pkg::OFM_FN_LATCHED &&
         !reset_cmd) |=> (state_ff == ofm_pkg::OFM_ST_LATCHED && o_alarm))
        else $error("latched alarm dropped");
    chk_disabled_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE11]
        !$past(enabled) |-> (!o_alarm && !o_control && o_relays == 5'h00))
        else $error("output while disabled");

    // ------------------------------------------------------------
    // checks: bus and interrupts
    // ------------------------------------------------------------
    chk_err_with_ready: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pslverr |-> o_pready)
        else $error("slave error outside an access");
    chk_ready_after_setup: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pready |-> $past(setup_acc))
        else $error("ready without a setup cycle");
    chk_irq_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_irq == ((irq_stat_ff & $past(irq_mask_ff)) != 3'h0))
        else $error("interrupt level disagrees with status");
    chk_irq_read_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        istat_rd |=> (irq_stat_ff == $past(events)))
        else $error("status read did not clear old events");

    // ------------------------------------------------------------
    // scenarios worth seeing in a run
    // ------------------------------------------------------------
    cov_operate: cover property (@(posedge i_clk) disable iff (!i_rst_n) ev_oper);
    cov_abort:   cover property (@(posedge i_clk) disable iff (!i_rst_n) ev_abort && !volt_ok);
    cov_latched: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        state_ff == ofm_pkg::OFM_ST_LATCHED ##1 reset_cmd);
    cov_control: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_control);
    cov_refused: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_pslverr);
endmodule // ofm_monitor
`default_nettype wire

// file: verification/ofm_meter_model.sv
// Purpose: metering front end model feeding frequency and phase A voltage
// Assumes: the meter refreshes its result once per clock
// Notes:   relays are watched by the bench directly
`timescale 1ns/100ps
`default_nettype none

module ofm_meter_model (
    input  wire logic        i_clk,
    input  wire logic [12:0] i_freq_set,
    input  wire logic [9:0]  i_volt_set,
    output logic      [12:0] o_freq,
    output logic      [9:0]  o_volt_a
);
    // one register stage, so a new reading lands a cycle late like a real meter
    always_ff @(posedge i_clk) begin
        o_freq   <= i_freq_set;
        o_volt_a <= i_volt_set;
    end
endmodule // ofm_meter_model

`default_nettype wire

// file: verification/tb_ofm_monitor.sv
// Purpose: self-checking bench for the overfrequency monitor
// Assumes: short delay step (STEP cycles) to keep the run small
// Notes:   APB master tasks, bounded waits, watchdog
`timescale 1ns/100ps
`default_nettype none
`include "ofm_params.svh"

module tb_ofm_monitor;
    localparam int STEP = 10;
    logic        clk, rst_n, psel, pen, pwr, pready, pslverr, e;
    logic        alarm, ctl, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [4:0]  relays;
    logic [12:0] fs, freq;
    logic [9:0]  vs, volt;
    int          miscompares, n_tests;

    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    ofm_meter_model u_meter (.i_clk(clk), .i_freq_set(fs), .i_volt_set(vs),
        .o_freq(freq), .o_volt_a(volt));
    ofm_monitor #(.STEP_CYCLES(STEP)) u_dut (.i_clk(clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_freq(freq), .i_volt_a(volt), .o_alarm(alarm),
        .o_control(ctl), .o_relays(relays), .o_irq(irq));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // one APB transfer; waits for pready rather than assuming a latency
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("ERROR t=%0t pready=%h exp=%h", $time, pready, 1'b1);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
        apb(1'b1, a, d);
        chk({31'h0, e}, {31'h0, xe});
    endtask

    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r & m, x);
    endtask

    task meas(input logic [12:0] f, input logic [9:0] v);
        @(posedge clk);
        fs <= f;
        vs <= v;
    endtask

    // bounded wait for the operate output (alarm or control) to reach x
    task wait_out(input logic x, input int n);
        int i;
        i = 0;
        while ((alarm | ctl) !== x && i < n) begin
            @(posedge clk);
            i++;
        end
        chk({31'h0, alarm | ctl}, {31'h0, x});
    endtask

    task outs_zero;
        chk({25'h0, ctl, alarm, relays}, 32'h0);
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // the tests need well under 2000 cycles; this only catches a hang
    initial begin
        #(40 * 20000);
        miscompares++;
        test_done();
    end

    initial begin
        rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; fs = 13'h0000; vs = 10'h000;
        miscompares = 0; n_tests = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(`OFM_ADDR_CTRL, 32'h1FF, 32'h1);
        rd(`OFM_ADDR_PICKUP, 32'h1FFF, 32'h17A2);
        rd(`OFM_ADDR_DELAY, 32'hFFFF, 32'h32);
        rd(`OFM_ADDR_IRQ_MASK, 32'h7, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(`OFM_ADDR_PICKUP, 32'h7CF, 1'b1);
        wr(`OFM_ADDR_PICKUP, 32'h1965, 1'b1);
        wr(`OFM_ADDR_PICKUP, 32'h7D0, 1'b0);
        wr(`OFM_ADDR_PICKUP, 32'h1964, 1'b0);
        rd(`OFM_ADDR_PICKUP, 32'h1FFF, 32'h1964);
        wr(`OFM_ADDR_DELAY, 32'hEA61, 1'b1);
        wr(`OFM_ADDR_DELAY, 32'hEA60, 1'b0);
        wr(`OFM_ADDR_CTRL, 32'h3, 1'b1);
        $display("test registers done");
        // disabled: measurement still readable, nothing operates
        wr(`OFM_ADDR_PICKUP, 32'h17A2, 1'b0);
        wr(`OFM_ADDR_DELAY, 32'h0, 1'b0);
        meas(13'h17D4, 10'h1F4);
        repeat (30) @(posedge clk);
        rd(`OFM_ADDR_FREQ, 32'h1FFF, 32'h17D4);
        outs_zero();
        $display("test disabled done");
        // alarm mode, delay two steps, frequency equal to pickup first
        meas(13'h17A2, 10'h12D);
        wr(`OFM_ADDR_DELAY, 32'h2, 1'b0);
        wr(`OFM_ADDR_IRQ_MASK, 32'h1, 1'b0);
        wr(`OFM_ADDR_CTRL, 32'h152, 1'b0);
        repeat (40) @(posedge clk);
        outs_zero();
        meas(13'h17A3, 10'h12D);
        repeat (15) @(posedge clk);
        outs_zero();
        wait_out(1'b1, 30);
        chk({27'h0, relays}, 32'h15);
        chk({31'h0, irq}, 32'h1);
        rd(`OFM_ADDR_IRQ_STAT, 32'h1, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        meas(13'h17A2, 10'h12D);
        wait_out(1'b0, 6);
        $display("test alarm done");
        // voltage exactly at the threshold inhibits
        meas(13'h17A3, 10'h12C);
        repeat (60) @(posedge clk);
        outs_zero();
        rd(`OFM_ADDR_STATUS, 32'hF, 32'h1);
        // voltage loss while timing resets silently
        rd(`OFM_ADDR_IRQ_STAT, 32'h7, 32'h0);
        wr(`OFM_ADDR_DELAY, 32'h5, 1'b0);
        meas(13'h17A3, 10'h12D);
        repeat (20) @(posedge clk);
        rd(`OFM_ADDR_STATUS, 32'hF, 32'h2);
        meas(13'h17A3, 10'h12C);
        repeat (70) @(posedge clk);
        outs_zero();
        rd(`OFM_ADDR_STATUS, 32'hF, 32'h1);
        rd(`OFM_ADDR_IRQ_STAT, 32'h4, 32'h4);
        $display("test supervision done");
        // latched alarm holds past the condition until the reset command
        meas(13'h0100, 10'h12D);
        wr(`OFM_ADDR_DELAY, 32'h0, 1'b0);
        wr(`OFM_ADDR_CTRL, 32'h1F4, 1'b0);
        meas(13'h17A3, 10'h12D);
        wait_out(1'b1, 10);
        chk({27'h0, relays}, 32'h1F);
        meas(13'h0100, 10'h12D);
        repeat (20) @(posedge clk);
        chk({31'h0, alarm}, 32'h1);
        wr(`OFM_ADDR_CMD, 32'h1, 1'b0);
        wait_out(1'b0, 5);
        $display("test latched done");
        // control mode drives the control output, then disabling drops it
        wr(`OFM_ADDR_CTRL, 32'h0A8, 1'b0);
        meas(13'h17A3, 10'h12D);
        wait_out(1'b1, 10);
        chk({30'h0, ctl, alarm}, 32'h2);
        chk({27'h0, relays}, 32'h0A);
        wr(`OFM_ADDR_CTRL, 32'h1, 1'b0);
        wait_out(1'b0, 6);
        outs_zero();
        $display("test control done");
        test_done();
    end
endmodule // tb_ofm_monitor

`default_nettype wire
